/* File: hw/bcs_sequencer.sv */
// Conversion sequencer with result store, alert and serial readback
//
// Overview of operation
// - One start pulse runs whole sequence
// - Chip-select rising edge starts when selected
// - Pin trigger after reset; control write changes
// - Default: six voltages then six temperatures
// - Options: voltages plus three temps, voltages only
// - Each channel takes at least 1us
// - Averaging of 2, 4 or 8 conversions
// - Reset averaging is single conversion
// - Each result goes to its channel register
// - Cell result is adjacent input difference
// - Results are 12-bit straight binary
// - Voltage and temperature code spans
// - Alert when result beyond thresholds
// - Readback over host-mastered 4-wire serial
// - Data passes down, control up chain
// - Six cell-balance outputs under control
// - Sequence field codes 00,01,10,11
// - Acquisition 400ns steps, 400ns default
`timescale 1ns/1ps
module bcs_sequencer import bcs_pkg::*; #(
  parameter int ACQ_STEP_CYCLES = ACQ_STEP_CYC,
  parameter int CONV_CYCLES     = CONV_CYC
) (
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              conversion_start_input_n_in,
  input  wire logic              spi_sclk_in,
  input  wire logic              spi_cs_n_in,
  input  wire logic              spi_sdi_in,
  input  wire logic              spi_sdi_hi_in,
  input  wire logic              alert_hi_in,
  input  wire logic              ctrl_wr_in,
  input  wire logic [1:0]        channel_sequence_select_in,
  input  wire logic [1:0]        acquisition_time_select_in,
  input  wire logic [1:0]        avg_select_in,
  input  wire logic              trig_select_in,
  input  wire logic [5:0]        balance_in,
  input  wire logic [CODE_W-1:0] vlt_hi_in,
  input  wire logic [CODE_W-1:0] vlt_lo_in,
  input  wire logic [CODE_W-1:0] tmp_hi_in,
  input  wire logic [CODE_W-1:0] tmp_lo_in,
  input  wire logic [CODE_W-1:0] adc_code_in,
  output logic                   adc_hold_out,
  output logic [2:0]             hv_mux_sel_out,
  output logic [2:0]             lv_mux_sel_out,
  output logic                   temp_path_out,
  output logic                   busy_out,
  output logic                   seq_done_out,
  output logic                   alert_out,
  output logic [5:0]             cell_balance_out,
  output logic                   spi_sdo_out,
  output logic                   spi_sdo_hi_out
);
  if (ACQ_STEP_CYCLES < 1 || ACQ_STEP_CYCLES * 4 > 128 || CONV_CYCLES < 1
      || CONV_CYCLES > 128) begin : g_bad_timing
    $error("bcs_sequencer: timing counts do not fit the 7-bit timer");
  end

  localparam logic [6:0] ACQ_STEP_7 = 7'(ACQ_STEP_CYCLES);
  localparam logic [6:0] CONV_7     = 7'(CONV_CYCLES);

  typedef struct packed {
    bcs_state_type                  st;
    logic [3:0]                     step;
    logic [1:0]                     ctl_seq;
    logic [1:0]                     ctl_acq;
    logic [1:0]                     ctl_avg;
    logic                           ctl_trig;
    logic [5:0]                     bal;
    logic [1:0]                     run_seq;
    logic [1:0]                     run_acq;
    logic [1:0]                     run_avg;
    logic [6:0]                     tmr;
    logic [2:0]                     navg;
    logic [14:0]                    acc;
    logic [NUM_CH-1:0][CODE_W-1:0]  res;
    logic [NUM_CH-1:0]              oor;
    logic                           busy;
    logic                           done;
    logic                           hold;
    logic                           alert;
    logic [2:0]                     hv;
    logic [2:0]                     lv;
    logic                           tpath;
    logic                           cnv_prev;
    logic                           cs_prev;
    logic                           req_prev;
    logic [15:0]                    rd_word;
  } bcs_core_type;

  bcs_core_type     q, next_q;
  logic [3:0]       sy;
  logic             link_req;
  logic [IDX_W-1:0] link_idx;
  logic             cnv_fall;
  logic             cs_rise;
  logic             req_rise;
  logic             trig_ev;
  logic [3:0]       cur_ch;
  logic [CODE_W-1:0] avg_code;

  // Step order: cell 6 down to cell 1, then temperatures
  function automatic logic [3:0] bcs_ch_of(input logic [3:0] step);
    if (step <= STEP_LAST_VOLT) begin
      bcs_ch_of = STEP_LAST_VOLT - step;
    end else begin
      bcs_ch_of = step;
    end
  endfunction

  // Returns {last, next step} for the running selection
  function automatic logic [4:0] bcs_next(input logic [3:0] step, input logic [1:0] seq);
    logic [3:0] nxt;
    logic       last;
    nxt  = step + 4'h1;
    last = 1'b0;
    unique case (seq)
      SEQ_SELF_TEST: last = 1'b1;
      SEQ_VOLT_ONLY: last = (step == STEP_LAST_VOLT);
      SEQ_ODD_TEMPS: begin
        last = (step == STEP_LAST_ODD);
        if (step >= STEP_FIRST_TEMP) begin
          nxt = step + 4'h2;
        end
      end
      SEQ_ALL: last = (step == STEP_LAST_TEMP);
    endcase
    bcs_next = {last, nxt};
  endfunction

  function automatic logic [6:0] bcs_acq_cyc(input logic [1:0] acq);
    bcs_acq_cyc = 7'(ACQ_STEP_7 * ({5'h00, acq} + 7'h01) - 7'h01);
  endfunction

  // Pins and the link request are levels from other domains
  bcs_sync2 #(
    .W       (4),
    .RST_VAL (4'h3)
  ) u_sync (
    .clk_in     (core_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({alert_hi_in, link_req, spi_cs_n_in, conversion_start_input_n_in}),
    .sync_out   (sy)
  );

  bcs_spi_link u_link (
    .sclk_in    (spi_sclk_in),
    .reset_n_in (reset_n_in),
    .cs_n_in    (spi_cs_n_in),
    .sdi_in     (spi_sdi_in),
    .sdi_hi_in  (spi_sdi_hi_in),
    .word_in    (q.rd_word),
    .sdo_out    (spi_sdo_out),
    .sdo_hi_out (spi_sdo_hi_out),
    .req_out    (link_req),
    .idx_out    (link_idx)
  );

  assign cnv_fall = q.cnv_prev & ~sy[0];
  assign cs_rise  = ~q.cs_prev & sy[1];
  assign req_rise = ~q.req_prev & sy[2];
  assign trig_ev  = (q.ctl_trig == TRIG_PIN) ? cnv_fall : cs_rise;
  assign cur_ch   = bcs_ch_of(q.step);
  assign avg_code = CODE_W'(q.acc >> q.run_avg);

  always_comb begin
    next_q          = q;
    next_q.done     = 1'b0;
    next_q.cnv_prev = sy[0];
    next_q.cs_prev  = sy[1];
    next_q.req_prev = sy[2];
    if (ctrl_wr_in) begin
      next_q.ctl_seq  = channel_sequence_select_in;
      next_q.ctl_acq  = acquisition_time_select_in;
      next_q.ctl_avg  = avg_select_in;
      next_q.ctl_trig = trig_select_in;
      next_q.bal      = balance_in;
    end
    // Index is held by the link well past the request, so it is stable here
    if (req_rise) begin
      if (link_idx < IDX_W'(NUM_CH)) begin
        next_q.rd_word = {link_idx, q.res[link_idx]};
      end else begin
        next_q.rd_word = {link_idx, {CODE_W{1'b0}}};
      end
    end
    unique case (q.st)
      ST_IDLE: begin
        // Triggers are looked at only here, so a running sequence is safe
        if (trig_ev) begin
          next_q.st      = ST_ACQ;
          next_q.busy    = 1'b1;
          next_q.run_seq = q.ctl_seq;
          next_q.run_acq = q.ctl_acq;
          next_q.run_avg = q.ctl_avg;
          next_q.tmr     = bcs_acq_cyc(q.ctl_acq);
          next_q.navg    = 3'h0;
          next_q.acc     = 15'h0000;
          next_q.step    = (q.ctl_seq == SEQ_SELF_TEST) ? STEP_SELF_TEST : 4'h0;
        end
      end
      ST_ACQ: begin
        if (q.tmr == 7'h00) begin
          next_q.st   = ST_CONV;
          next_q.hold = 1'b1;
          next_q.tmr  = CONV_7 - 7'h01;
        end else begin
          next_q.tmr = q.tmr - 7'h01;
        end
      end
      ST_CONV: begin
        if (q.tmr == 7'h00) begin
          next_q.hold = 1'b0;
          next_q.acc  = q.acc + {3'h0, adc_code_in};
          if (q.navg == 3'((4'h1 << q.run_avg) - 4'h1)) begin
            next_q.st = ST_STORE;
          end else begin
            next_q.navg = q.navg + 3'h1;
            next_q.st   = ST_ACQ;
            next_q.tmr  = bcs_acq_cyc(q.run_acq);
          end
        end else begin
          next_q.tmr = q.tmr - 7'h01;
        end
      end
      ST_STORE: begin
        next_q.res[cur_ch] = avg_code;
        // Voltage and temperature codes have different scales, so each has its own limits
        if (cur_ch <= 4'(NUM_CELLS - 1)) begin
          next_q.oor[cur_ch] = (avg_code > vlt_hi_in) || (avg_code < vlt_lo_in);
        end else begin
          next_q.oor[cur_ch] = (avg_code > tmp_hi_in) || (avg_code < tmp_lo_in);
        end
        next_q.navg = 3'h0;
        next_q.acc  = 15'h0000;
        if (bcs_next(q.step, q.run_seq) >> 4 != 5'h00) begin
          next_q.st   = ST_IDLE;
          next_q.busy = 1'b0;
          next_q.done = 1'b1;
          next_q.step = 4'h0;
        end else begin
          next_q.st   = ST_ACQ;
          next_q.step = 4'(bcs_next(q.step, q.run_seq));
          next_q.tmr  = bcs_acq_cyc(q.run_acq);
        end
      end
    endcase
    next_q.alert = (|q.oor) | sy[3];
    // Idle leaves cell 6 selected so it is tracked for the next request
    if (bcs_ch_of(next_q.step) <= 4'(NUM_CELLS - 1)) begin
      next_q.hv    = 3'(bcs_ch_of(next_q.step));
      next_q.tpath = 1'b0;
    end else if (next_q.step == STEP_SELF_TEST) begin
      next_q.hv    = 3'h0;
      next_q.tpath = 1'b0;
    end else begin
      next_q.lv    = 3'(bcs_ch_of(next_q.step) - STEP_FIRST_TEMP);
      next_q.tpath = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q          <= '0;
      q.st       <= ST_IDLE;
      q.ctl_seq  <= CTRL_SEQ_RST;
      q.ctl_acq  <= CTRL_ACQ_RST;
      q.ctl_avg  <= CTRL_AVG_RST;
      q.ctl_trig <= CTRL_TRIG_RST;
      q.bal      <= CTRL_BAL_RST;
      q.hv       <= 3'h5;
      q.cnv_prev <= 1'b1;
      q.cs_prev  <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign adc_hold_out     = q.hold;
  assign hv_mux_sel_out   = q.hv;
  assign lv_mux_sel_out   = q.lv;
  assign temp_path_out    = q.tpath;
  assign busy_out         = q.busy;
  assign seq_done_out     = q.done;
  assign alert_out        = q.alert;
  assign cell_balance_out = q.bal;

  // Cycles spent on one channel, all its acquisitions and conversions included
  logic [7:0] chk_cnt;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chk_cnt <= 8'h00;
    end else if (q.st == ST_ACQ || q.st == ST_CONV) begin
      chk_cnt <= chk_cnt + 8'h01;
    end else begin
      chk_cnt <= 8'h00;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_trig_starts;
    q.st == ST_IDLE && trig_ev |=> busy_out && q.st == ST_ACQ;
  endproperty
  a_trig_starts: assert property (p_trig_starts)
    else $error("trigger did not start a sequence");

  property p_trig_hold;
    !ctrl_wr_in |=> q.ctl_trig == $past(q.ctl_trig);
  endproperty
  a_trig_hold: assert property (p_trig_hold)
    else $error("trigger source changed without a write");

  property p_ignore_busy;
    q.st != ST_IDLE && trig_ev |=>
      q.run_seq == $past(q.run_seq) && (busy_out || seq_done_out);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy)
    else $error("trigger disturbed a running sequence");

  property p_min_time;
    q.st == ST_CONV && q.tmr == 7'h00 && q.navg == 3'h0 |->
      {1'b0, chk_cnt} + 9'h001 >= 9'(ACQ_STEP_CYCLES + CONV_CYCLES);
  endproperty
  a_min_time: assert property (p_min_time)
    else $error("channel measurement shorter than minimum");

  property p_avg_count;
    q.st == ST_STORE |-> q.navg == 3'((4'h1 << q.run_avg) - 4'h1);
  endproperty
  a_avg_count: assert property (p_avg_count)
    else $error("wrong number of averaged conversions");

  property p_store;
    q.st == ST_STORE |=> q.res[$past(cur_ch)] == $past(avg_code);
  endproperty
  a_store: assert property (p_store)
    else $error("result not stored in its channel register");

  property p_volt_only;
    q.st == ST_STORE && q.run_seq == SEQ_VOLT_ONLY |-> cur_ch < 4'(NUM_CELLS);
  endproperty
  a_volt_only: assert property (p_volt_only)
    else $error("temperature converted in voltage-only mode");

  property p_odd_temps;
    q.st == ST_STORE && q.run_seq == SEQ_ODD_TEMPS && cur_ch >= STEP_FIRST_TEMP
      |-> !cur_ch[0];
  endproperty
  a_odd_temps: assert property (p_odd_temps)
    else $error("wrong temperature channel in reduced mode");

  property p_alert;
    (|q.oor) |=> alert_out;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert missing for out-of-range result");

  property p_hv_sel;
    q.st == ST_ACQ && cur_ch < 4'(NUM_CELLS) |-> hv_mux_sel_out == 3'(cur_ch) && !temp_path_out;
  endproperty
  a_hv_sel: assert property (p_hv_sel)
    else $error("cell multiplexer does not match channel");
endmodule // bcs_sequencer

/* File: hw/bcs_spi_link.sv */
// Serial link on the host clock: index capture, readback and chain relay
`timescale 1ns/1ps
module bcs_spi_link import bcs_pkg::*; (
  input  wire logic             sclk_in,
  input  wire logic             reset_n_in,
  input  wire logic             cs_n_in,
  input  wire logic             sdi_in,
  input  wire logic             sdi_hi_in,
  input  wire logic [15:0]      word_in,
  output logic                  sdo_out,
  output logic                  sdo_hi_out,
  output logic                  req_out,
  output logic      [IDX_W-1:0] idx_out
);
  typedef struct packed {
    logic [4:0]       cnt;
    logic [15:0]      tx;
    logic [IDX_W-1:0] rx;
    logic             sdo;
    logic             sdo_hi;
    logic             req;
  } bcs_link_type;

  bcs_link_type q, next_q;
  logic         frame_rst_n;

  // The clock stops between frames, so the frame select ends the frame state
  assign frame_rst_n = reset_n_in & ~cs_n_in;

  always_comb begin
    next_q        = q;
    next_q.sdo_hi = sdi_in;
    if (q.cnt < 5'(FRAME_BITS)) begin
      next_q.cnt = q.cnt + 5'h01;
    end
    if (q.cnt < 5'(IDX_W)) begin
      next_q.rx = {q.rx[IDX_W-2:0], sdi_in};
    end
    if (q.cnt == 5'(IDX_W)) begin
      next_q.req = 1'b1;
    end
    if (q.cnt == 5'h00) begin
      next_q.sdo = word_in[15];
      next_q.tx  = {word_in[14:0], sdi_hi_in};
    end else begin
      next_q.sdo = q.tx[15];
      next_q.tx  = {q.tx[14:0], sdi_hi_in};
    end
  end

  always_ff @(posedge sclk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign sdo_out    = q.sdo;
  assign sdo_hi_out = q.sdo_hi;
  assign req_out    = q.req;
  assign idx_out    = q.rx;
endmodule // bcs_spi_link

/* File: hw/bcs_sync2.sv */
// Two-flop synchroniser for single-bit levels
`timescale 1ns/1ps
module bcs_sync2 #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bcs_sync_type;

  bcs_sync_type q, next_q;

  // First stage is read only by the second stage
  always_comb begin
    next_q    = q;
    next_q.s1 = async_in;
    next_q.s2 = q.s1;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= {RST_VAL, RST_VAL};
    end else begin
      q <= next_q;
    end
  end

  assign sync_out = q.s2;
endmodule // bcs_sync2

/* File: pkg/bcs_pkg.sv */
// Shared constants and types of the battery cell conversion sequencer
package bcs_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ACQ_STEP_NS   = 400;
  localparam int CONV_TIME_NS  = 600;
  localparam int ACQ_STEP_CYC  = (ACQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CODE_W        = 12;
  localparam int NUM_CELLS     = 6;
  localparam int NUM_CH        = 13;
  localparam int IDX_W         = 4;
  localparam int FRAME_BITS    = 16;
  localparam int VLT_LSB_UV    = 976;
  localparam int TMP_LSB_UV    = 1220;
  localparam logic [3:0] STEP_FIRST_TEMP = 4'h6;
  localparam logic [3:0] STEP_LAST_VOLT  = 4'h5;
  localparam logic [3:0] STEP_LAST_TEMP  = 4'hb;
  localparam logic [3:0] STEP_LAST_ODD   = 4'ha;
  localparam logic [3:0] STEP_SELF_TEST  = 4'hc;
  localparam logic [1:0] SEQ_ALL         = 2'h0;
  localparam logic [1:0] SEQ_ODD_TEMPS   = 2'h1;
  localparam logic [1:0] SEQ_VOLT_ONLY   = 2'h2;
  localparam logic [1:0] SEQ_SELF_TEST   = 2'h3;
  localparam logic       TRIG_PIN        = 1'b0;
  localparam logic       TRIG_CS         = 1'b1;
  localparam logic [1:0] CTRL_SEQ_RST    = 2'h0;
  localparam logic [1:0] CTRL_ACQ_RST    = 2'h0;
  localparam logic [1:0] CTRL_AVG_RST    = 2'h0;
  localparam logic       CTRL_TRIG_RST   = TRIG_PIN;
  localparam logic [5:0] CTRL_BAL_RST    = 6'h00;
  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV, ST_STORE} bcs_state_type;
endpackage

/* File: verif/bcs_host_model.sv */
// Serial host model: framed link clock, index frames and word reads
`timescale 1ns/1ps
module bcs_host_model (
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      sdi_out,
  output logic      sdi_hi_out,
  input  wire logic sdo_in,
  input  wire logic sdo_hi_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
    sdi_hi_out = 1'b0;
  end
  // Clock runs only inside a frame; host shifts on fall, samples on fall
  task automatic frame(input int n, input logic [31:0] tx, tx_hi,
                       output logic [31:0] rx, rx_hi);
    rx = 32'h0;
    rx_hi = 32'h0;
    #7 cs_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi_out = tx[n - 1 - i];
      sdi_hi_out = tx_hi[n - 1 - i];
      #32 sclk_out = 1'b1;
      #32 sclk_out = 1'b0;
      rx = {rx[30:0], sdo_in};
      rx_hi = {rx_hi[30:0], sdo_hi_in};
    end
    #100 cs_n_out = 1'b1;
    // Released lines show the inverse so stale values never pass
    sdi_out = ~sdi_out;
    sdi_hi_out = ~sdi_hi_out;
    #200;
  endtask
endmodule // bcs_host_model

/* File: verif/tb_bcs_sequencer.sv */
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module tb_bcs_sequencer import bcs_pkg::*;;
  localparam int A = 2;
  localparam int C = 3;
  logic              core_clk_in, reset_n_in, start_n, cwr, trig, sclk, cs_n, sdi, sdi_hi;
  logic              hi_alert, hold, busy, done, alert, sdo, sdo_hi, temp, hold_q, done_seen;
  logic [1:0]        seq, acq, avg, rs;
  logic [2:0]        hv, lv;
  logic [5:0]        bal, cb;
  logic [CODE_W-1:0] vhi, vlo, thi, tlo, code;
  logic [CODE_W-1:0] base [13];
  int                miscompares, check_count, seed, nconv, bcyc, ch;

  bcs_sequencer #(.ACQ_STEP_CYCLES(A), .CONV_CYCLES(C)) i_dut (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .conversion_start_input_n_in(start_n), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
    .spi_sdi_in(sdi), .spi_sdi_hi_in(sdi_hi), .alert_hi_in(hi_alert), .ctrl_wr_in(cwr),
    .channel_sequence_select_in(seq), .acquisition_time_select_in(acq),
    .avg_select_in(avg), .trig_select_in(trig), .balance_in(bal), .vlt_hi_in(vhi),
    .vlt_lo_in(vlo), .tmp_hi_in(thi), .tmp_lo_in(tlo), .adc_code_in(code),
    .adc_hold_out(hold), .hv_mux_sel_out(hv), .lv_mux_sel_out(lv), .temp_path_out(temp),
    .busy_out(busy), .seq_done_out(done), .alert_out(alert), .cell_balance_out(cb),
    .spi_sdo_out(sdo), .spi_sdo_hi_out(sdo_hi));

  bcs_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
    .sdi_hi_out(sdi_hi), .sdo_in(sdo), .sdo_hi_in(sdo_hi));

  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  always_comb ch = (seq == 2'h3) ? 12 : temp ? 6 + int'(lv) : int'(hv);

  // Converter model: code steps by one per averaged conversion of a channel
  always @(posedge core_clk_in) begin
    hold_q <= hold;
    if (hold && !hold_q) nconv <= nconv + 1;
    if (busy) bcyc <= bcyc + 1;
    if (done) done_seen <= 1'b1;
    if (hold) code <= base[ch] + 12'((nconv + int'(!hold_q) - 1) % (1 << avg));
  end

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [1:0] s, a, v, input logic t);
    @(posedge core_clk_in);
    seq <= s;
    acq <= a;
    avg <= v;
    trig <= t;
    bal <= 6'($random(seed));
    cwr <= 1'b1;
    @(posedge core_clk_in);
    cwr <= 1'b0;
    @(negedge core_clk_in);
    cmp("balance", bal, cb);
  endtask

  task automatic pulse();
    @(posedge core_clk_in);
    start_n <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    start_n <= 1'b1;
    repeat (4) @(posedge core_clk_in);
  endtask

  function automatic bit conv(input logic [1:0] s, input int i);
    if (s == 2'h3) return i == 12;
    return i < 6 || (i < 12 && (s == 2'h0 || (s == 2'h1 && i % 2 == 0)));
  endfunction

  task automatic run(input bit w, input logic [1:0] s, a, v, input logic t, input int hot);
    logic [31:0] rx, rxh, tx;
    int          n, nch;
    n = 1 << v;
    nch = (s == 2'h0) ? 12 : (s == 2'h1) ? 9 : (s == 2'h2) ? 6 : 1;
    vhi <= (hot == 1) ? base[2] - 12'h001 : 12'hfff;
    tlo <= (hot == 2) ? base[8] + 12'h004 : 12'h000;
    if (w) begin
      wr(s, a, v, t);
      repeat (4500) @(posedge core_clk_in);
    end
    @(negedge core_clk_in);
    nconv = 0;
    bcyc = 0;
    done_seen = 1'b0;
    pulse();
    if (t) begin
      cmp("busy", 0, busy);
      i_host.frame(8, 0, 0, rx, rxh);
    end else pulse();
    for (int i = 0; i < 20000 && !done_seen; i++) @(posedge core_clk_in);
    if (!done_seen) begin
      miscompares++;
      $display("BAD seq_done exp 1 got 0");
      finish_test();
    end
    @(posedge core_clk_in);
    cmp("conversions", nch * n, nconv);
    cmp("busy cycles", nch * (n * (A * (a + 1) + C) + 1), bcyc);
    cmp("alert", hot != 0, alert);
    // Back to the pin trigger so the read frames start no new sequence
    if (t) wr(s, a, v, 1'b0);
    // Reads start only once the whole sequence has ended
    for (int i = 0; i < 14; i++) begin
      if (conv(s, i) || i == 13) begin
        tx = $random(seed);
        i_host.frame(8, {24'h0, 4'(i), 4'h0}, 0, rx, rxh);
        i_host.frame(32, tx, tx, rx, rxh);
        cmp("result", (i == 13) ? 32'hd000 : {16'h0, 4'(i), base[i] + 12'((n - 1) / 2)},
            rx[31:16]);
        cmp("relay down", tx[31:16], rx[15:0]);
        cmp("relay up", tx, rxh);
      end
    end
    $display("test seq %0d acq %0d avg %0d trig %0d ended", s, a, v, t);
  endtask

  initial begin
    seed = 65494;
    reset_n_in = 1'b0;
    {start_n, cwr, trig, hi_alert, seq, acq, avg, bal} = 16'h8000;
    {vhi, vlo, thi, tlo, code} = {12'hfff, 12'h000, 12'hfff, 24'h0};
    {nconv, bcyc, done_seen, hold_q} = '0;
    for (int i = 0; i < 13; i++) base[i] = 12'h010 + {1'b0, 11'($random(seed))};
    repeat (16) @(posedge core_clk_in);
    cmp("reset outputs", 13'h0a00, {1'b0, hv, busy, alert, cb, done});
    reset_n_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    run(0, 2'h0, 2'h0, 2'h0, 1'b0, 0);
    run(1, 2'h2, 2'h1, 2'h1, 1'b0, 1);
    run(1, 2'h1, 2'h2, 2'h2, 1'b0, 2);
    run(1, 2'h0, 2'h3, 2'h3, 1'b1, 0);
    run(1, 2'h3, 2'h3, 2'h0, 1'b0, 0);
    for (int r = 0; r < 3; r++) begin
      rs = 2'($random(seed));
      run(1, rs, 2'($random(seed)), (rs == 2'h3) ? 2'h0 : 2'($random(seed)),
          1'($random(seed)), 0);
    end
    hi_alert <= 1'b1;
    repeat (5) @(posedge core_clk_in);
    cmp("alert chain", 1, alert);
    hi_alert <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    cmp("alert chain", 0, alert);
    finish_test();
  end
endmodule // tb_bcs_sequencer
